/* pkg/dsle_map.svh */
// register offsets, field positions, reset values and timing counts of the event and mask bank
`ifndef DSLE_MAP_SVH
`define DSLE_MAP_SVH

// =====================================================================
// register offsets
`define DSLE_ADDR_EVT        8'hC2
`define DSLE_ADDR_HWM        8'hD0
`define DSLE_ADDR_SWM        8'hD1

// =====================================================================
// reset values
`define DSLE_EVT_RESET       8'h04
`define DSLE_MASK_RESET      8'hFF

// =====================================================================
// event flag field positions
`define DSLE_BIT_OVERLAP     3
`define DSLE_BIT_RESET_EVT   2
`define DSLE_BIT_IFACE_ERR   1
`define DSLE_EVT_LIVE_MASK   8'h0E

// =====================================================================
// timing
`define DSLE_CLK_PERIOD_NS   40
`define DSLE_OVL_TIME_NS     640
`define DSLE_OVL_CYCLES      ((`DSLE_OVL_TIME_NS + `DSLE_CLK_PERIOD_NS - 1) / `DSLE_CLK_PERIOD_NS)

`endif

/* pkg/dsle_pkg.sv */
// types and decode helper shared by the event and mask bank
package dsle_pkg;

  // =====================================================================
  // types
  typedef logic [7:0] dsle_byte_t;

  typedef enum logic [1:0]
  {
    DSLE_SEL_NONE = 2'b00,
    DSLE_SEL_EVT  = 2'b01,
    DSLE_SEL_HWM  = 2'b10,
    DSLE_SEL_SWM  = 2'b11
  } dsle_sel_t;

  // =====================================================================
  // address decode, used by write and read paths
  function automatic dsle_sel_t dsle_decode(input dsle_byte_t addr);
    dsle_sel_t sel;
    unique case (addr)
      8'hC2:   sel = DSLE_SEL_EVT;
      8'hD0:   sel = DSLE_SEL_HWM;
      8'hD1:   sel = DSLE_SEL_SWM;
      default: sel = DSLE_SEL_NONE;
    endcase
    return sel;
  endfunction : dsle_decode

endpackage : dsle_pkg

/* pkg/dsle_upd_if.sv */
// carrier between the bank and its update overlap timer
`timescale 1ns/100ps
interface dsle_upd_if;
  logic upd_attempt;  // one-cycle channel update attempt
  logic overlap;      // attempt came inside the guard window

  modport bank
  (
    output upd_attempt,
    input  overlap
  );

  modport timer
  (
    input  upd_attempt,
    output overlap
  );
endinterface : dsle_upd_if

/* rtl/dsle_ovl_timer.sv */
// guard window timer that flags channel updates arriving too soon
`timescale 1ns/100ps
`include "dsle_map.svh"
module dsle_ovl_timer
  import dsle_pkg::*;
#(
  parameter int OVL_CYCLES = `DSLE_OVL_CYCLES
)
(
  input  wire logic  sys_clk,
  input  wire logic  reset_n,
  dsle_upd_if.timer  upd
);

  localparam int CW = $clog2(OVL_CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(OVL_CYCLES - 1);

  // =====================================================================
  // elaboration check
  if (OVL_CYCLES < 2)
  begin : g_bad_window
    $error("dsle_ovl_timer: OVL_CYCLES must be at least 2");
  end

  logic [CW-1:0] win_cnt_reg;
  logic [CW-1:0] win_cnt_next;

  // =====================================================================
  // window counter: restarts on every attempt, counts down to idle
  always_comb
  begin
    win_cnt_next = win_cnt_reg;
    if (upd.upd_attempt)
    begin
      win_cnt_next = LOAD;
    end
    else if (win_cnt_reg != '0)
    begin
      win_cnt_next = win_cnt_reg - CW'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      win_cnt_reg <= '0;
    end
    else
    begin
      win_cnt_reg <= win_cnt_next;
    end
  end

  // attempt while the window is still open is an overlap
  assign upd.overlap = upd.upd_attempt && (win_cnt_reg != '0);

  // =====================================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  property p_window_load;
    upd.upd_attempt |=> (win_cnt_reg == LOAD);
  endproperty
  a_window_load: assert property (p_window_load)
    else $error("window not reloaded after update attempt");

  property p_spaced_ok;
    upd.upd_attempt ##1 (!upd.upd_attempt [*8]) ##1 (!upd.upd_attempt [*7])
      ##1 upd.upd_attempt |-> !upd.overlap;
  endproperty
  a_spaced_ok: assert property (p_spaced_ok)
    else $error("update spaced by full window was flagged");

endmodule : dsle_ovl_timer

/* rtl/dsle_bank.sv */
// event flags and hardware/software load enable masks of an eight-channel converter
`timescale 1ns/100ps
`include "dsle_map.svh"

module dsle_bank
  import dsle_pkg::*;
#(
  parameter int OVL_CYCLES = `DSLE_OVL_CYCLES
)
(
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  input  wire dsle_byte_t reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire dsle_byte_t reg_wdata,
  output      dsle_byte_t reg_rdata,
  input  wire logic       upd_attempt,
  input  wire logic       iface_err_any,
  input  wire logic       reset_event,
  input  wire logic       load_strobe,
  input  wire dsle_byte_t sw_load_req,
  output      dsle_byte_t hw_load_go,
  output      dsle_byte_t sw_load_go
);

  // =====================================================================
  // elaboration check
  if (OVL_CYCLES < 2)
  begin : g_bad_window
    $error("dsle_bank: OVL_CYCLES must be at least 2");
  end

  dsle_byte_t evt_flags_reg;
  dsle_byte_t evt_flags_next;
  dsle_byte_t hw_load_enable_reg;
  dsle_byte_t hw_load_enable_next;
  dsle_byte_t sw_load_enable_reg;
  dsle_byte_t sw_load_enable_next;
  dsle_byte_t rdata_reg;
  dsle_byte_t rdata_next;
  dsle_byte_t hw_go_reg;
  dsle_byte_t hw_go_next;
  dsle_byte_t sw_go_reg;
  dsle_byte_t sw_go_next;
  dsle_sel_t  sel;

  dsle_upd_if upd ();

  // =====================================================================
  // update overlap timer
  assign upd.upd_attempt = upd_attempt;

  dsle_ovl_timer #(
    .OVL_CYCLES (OVL_CYCLES)
  ) u_ovl_timer (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .upd     (upd.timer)
  );

  assign sel = dsle_decode(reg_addr);

  // =====================================================================
  // event flags: write-one clear first, then hardware sets win
  always_comb
  begin
    evt_flags_next = evt_flags_reg;
    if (reg_wr && (sel == DSLE_SEL_EVT))
    begin
      evt_flags_next = evt_flags_reg & ~(reg_wdata & `DSLE_EVT_LIVE_MASK);
    end
    if (upd.overlap)
    begin
      evt_flags_next[`DSLE_BIT_OVERLAP] = 1'b1;
    end
    if (reset_event)
    begin
      evt_flags_next[`DSLE_BIT_RESET_EVT] = 1'b1;
    end
    if (iface_err_any)
    begin
      evt_flags_next[`DSLE_BIT_IFACE_ERR] = 1'b1;
    end
    evt_flags_next = evt_flags_next & `DSLE_EVT_LIVE_MASK;
  end

  // =====================================================================
  // load enable masks: plain read/write
  always_comb
  begin
    hw_load_enable_next = hw_load_enable_reg;
    sw_load_enable_next = sw_load_enable_reg;
    if (reg_wr && (sel == DSLE_SEL_HWM))
    begin
      hw_load_enable_next = reg_wdata;
    end
    if (reg_wr && (sel == DSLE_SEL_SWM))
    begin
      sw_load_enable_next = reg_wdata;
    end
  end

  // =====================================================================
  // read data: captured on a read, held until the next one
  always_comb
  begin
    rdata_next = rdata_reg;
    if (reg_rd)
    begin
      unique case (sel)
        DSLE_SEL_EVT:  rdata_next = evt_flags_reg;
        DSLE_SEL_HWM:  rdata_next = hw_load_enable_reg;
        DSLE_SEL_SWM:  rdata_next = sw_load_enable_reg;
        DSLE_SEL_NONE: rdata_next = 8'h00;
      endcase
    end
  end

  // =====================================================================
  // per-channel load gating with the masks as they stand
  always_comb
  begin
    hw_go_next = load_strobe ? hw_load_enable_reg : 8'h00;
    sw_go_next = sw_load_req & sw_load_enable_reg;
  end

  // =====================================================================
  // registers
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      evt_flags_reg      <= `DSLE_EVT_RESET;   // reset event reads back set
      hw_load_enable_reg <= `DSLE_MASK_RESET;
      sw_load_enable_reg <= `DSLE_MASK_RESET;
      rdata_reg          <= 8'h00;
      hw_go_reg          <= 8'h00;
      sw_go_reg          <= 8'h00;
    end
    else
    begin
      evt_flags_reg      <= evt_flags_next;
      hw_load_enable_reg <= hw_load_enable_next;
      sw_load_enable_reg <= sw_load_enable_next;
      rdata_reg          <= rdata_next;
      hw_go_reg          <= hw_go_next;
      sw_go_reg          <= sw_go_next;
    end
  end

  assign reg_rdata  = rdata_reg;
  assign hw_load_go = hw_go_reg;
  assign sw_load_go = sw_go_reg;

  // =====================================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence s_close_updates;
    upd_attempt ##[1:15] upd_attempt;
  endsequence

  sequence s_clear_overlap;
    reg_wr && (reg_addr == 8'hC2) && reg_wdata[3] && !upd.overlap;
  endsequence

  property p_reset_values;
    $rose(reset_n) |-> (evt_flags_reg == 8'h04) && (hw_load_enable_reg == 8'hFF)
      && (sw_load_enable_reg == 8'hFF);
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("register reset values wrong");

  property p_overlap_set;
    s_close_updates |=> evt_flags_reg[3];
  endproperty
  a_overlap_set: assert property (p_overlap_set)
    else $error("close updates did not set overlap flag");

  property p_overlap_clear;
    s_clear_overlap |=> !evt_flags_reg[3];
  endproperty
  a_overlap_clear: assert property (p_overlap_clear)
    else $error("write one did not clear overlap flag");

  property p_overlap_sticky;
    evt_flags_reg[3] && !(reg_wr && (reg_addr == 8'hC2) && reg_wdata[3])
      |=> evt_flags_reg[3] [*2] or (evt_flags_reg[3] ##1 1'b1);
  endproperty
  a_overlap_sticky: assert property (p_overlap_sticky)
    else $error("overlap flag dropped without a clear");

  property p_reset_event;
    reset_event |=> evt_flags_reg[2];
  endproperty
  a_reset_event: assert property (p_reset_event)
    else $error("reset event flag not set");

  property p_iface_set_wins;
    iface_err_any |=> evt_flags_reg[1];
  endproperty
  a_iface_set_wins: assert property (p_iface_set_wins)
    else $error("interface fault flag not set");

  property p_reserved_zero;
    (evt_flags_reg[7:4] == 4'h0) && !evt_flags_reg[0];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved event bits not zero");

  property p_hw_gate;
    load_strobe |=> (hw_load_go == $past(hw_load_enable_reg));
  endproperty
  a_hw_gate: assert property (p_hw_gate)
    else $error("hardware load not gated by mask");

  property p_sw_gate;
    1'b1 |=> (sw_load_go == ($past(sw_load_req) & $past(sw_load_enable_reg)));
  endproperty
  a_sw_gate: assert property (p_sw_gate)
    else $error("software load not gated by mask");

  property p_mask_readback;
    reg_wr && (reg_addr == 8'hD0) ##1 reg_rd && (reg_addr == 8'hD0) && !reg_wr
      |=> (reg_rdata == $past(reg_wdata, 2));
  endproperty
  a_mask_readback: assert property (p_mask_readback)
    else $error("hardware mask read back wrong");

endmodule : dsle_bank

/* dv/dsle_host_model.sv */
// host model issuing register writes and reads on the bank port
`timescale 1ns/100ps
module dsle_host_model
  import dsle_pkg::*;
(
  input  wire logic       sys_clk,
  output      dsle_byte_t reg_addr,
  output      logic       reg_wr,
  output      logic       reg_rd,
  output      dsle_byte_t reg_wdata,
  input  wire dsle_byte_t reg_rdata
);
  // =====================================================================
  // idle port at time zero
  initial
  begin
    reg_addr  = 8'h00;
    reg_wr    = 1'h0;
    reg_rd    = 1'h0;
    reg_wdata = 8'h00;
  end

  // =====================================================================
  // one-cycle write strobe, taken at the next edge
  task wr(input dsle_byte_t a, input dsle_byte_t d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'h1;
    @(posedge sys_clk);
    reg_wr    <= 1'h0;
    reg_wdata <= ~d;  // stale data never looks valid
  endtask : wr

  // one-cycle read strobe, data valid after the taking edge
  task rd(input dsle_byte_t a, output dsle_byte_t d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    #1;
    d = reg_rdata;
  endtask : rd

  // write then read back in the very next cycle, as the bank allows
  task wr_rd(input dsle_byte_t a, input dsle_byte_t dw, output dsle_byte_t d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= dw;
    reg_wr    <= 1'h1;
    @(posedge sys_clk);
    reg_wr    <= 1'h0;
    reg_wdata <= ~dw;
    reg_rd    <= 1'h1;
    @(posedge sys_clk);
    reg_rd    <= 1'h0;
    #1;
    d = reg_rdata;
  endtask : wr_rd
endmodule : dsle_host_model

/* dv/test_dsle_bank.sv */
// self-checking bench for the event flag and load mask bank
`timescale 1ns/100ps
module test_dsle_bank
  import dsle_pkg::*;
;
  logic        sys_clk = 1'h0;
  logic        reset_n = 1'h0;
  dsle_byte_t  reg_addr, reg_wdata, reg_rdata, hw_load_go, sw_load_go;
  logic        reg_wr, reg_rd;
  logic        upd_attempt = 1'h0;
  logic        iface_err_any = 1'h0;
  logic        reset_event = 1'h0;
  logic        load_strobe = 1'h0;
  dsle_byte_t  sw_load_req = 8'h00;
  dsle_byte_t  m, s, r, r2;
  int          num_errors = 0;
  int          comparisons = 0;
  logic [31:0] rng = 32'h0000001E;

  // =====================================================================
  // clock and design
  always #20 sys_clk = ~sys_clk;

  dsle_bank uut
  (
    .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .upd_attempt(upd_attempt), .iface_err_any(iface_err_any),
    .reset_event(reset_event), .load_strobe(load_strobe), .sw_load_req(sw_load_req),
    .hw_load_go(hw_load_go), .sw_load_go(sw_load_go)
  );

  dsle_host_model host
  (
    .sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata)
  );

  // =====================================================================
  // helpers
  function automatic dsle_byte_t xorshift();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng[7:0];
  endfunction : xorshift

  task chk(input dsle_byte_t got, input dsle_byte_t exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task rchk(input dsle_byte_t a, input dsle_byte_t exp);
    dsle_byte_t d;
    host.rd(a, d);
    chk(d, exp);
  endtask : rchk

  // two update attempts gap cycles apart, after a quiet spell
  task upd_pair(input int gap);
    repeat (20) @(posedge sys_clk);
    upd_attempt <= 1'h1;
    @(posedge sys_clk);
    upd_attempt <= 1'h0;
    repeat (gap - 1) @(posedge sys_clk);
    upd_attempt <= 1'h1;
    @(posedge sys_clk);
    upd_attempt <= 1'h0;
  endtask : upd_pair

  task summarize();
    $display("errors=%0d comparisons=%0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize

  // =====================================================================
  // hang guard
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    num_errors++;
    summarize();
  end

  // =====================================================================
  // main sequence
  initial
  begin
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'h1;
    rchk(8'hC2, 8'h04);
    host.wr(8'hD2, 8'h00);
    rchk(8'hD0, 8'hFF);
    rchk(8'hD1, 8'hFF);
    rchk(8'hD2, 8'h00);
    host.wr(8'hC2, 8'hFB);
    rchk(8'hC2, 8'h04);
    @(posedge sys_clk);
    reset_event <= 1'h1;
    host.wr(8'hC2, 8'h04);
    reset_event <= 1'h0;
    rchk(8'hC2, 8'h04);
    host.wr(8'hC2, 8'h04);
    rchk(8'hC2, 8'h00);
    @(posedge sys_clk);
    iface_err_any <= 1'h1;
    @(posedge sys_clk);
    iface_err_any <= 1'h0;
    rchk(8'hC2, 8'h02);
    host.wr(8'hC2, 8'hFF);
    upd_pair(15);
    rchk(8'hC2, 8'h08);
    host.wr(8'hC2, 8'h08);
    upd_pair(16);
    rchk(8'hC2, 8'h00);
    // random masks with all-off and all-on corners
    for (int i = 0; i < 40; i++)
    begin
      m = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : xorshift();
      s = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : xorshift();
      r = xorshift();
      r2 = xorshift();
      host.wr(8'hD0, m);
      host.wr(8'hD1, s);
      rchk(8'hD0, m);
      rchk(8'hD1, s);
      @(posedge sys_clk);
      load_strobe <= 1'h1;
      sw_load_req <= r;
      @(posedge sys_clk);
      load_strobe <= 1'h0;
      sw_load_req <= r2;
      #1;
      chk(hw_load_go, m);
      chk(sw_load_go, r & s);
      @(posedge sys_clk);
      sw_load_req <= 8'h00;
      #1;
      chk(hw_load_go, 8'h00);
      chk(sw_load_go, r2 & s);
    end
    // back-to-back write and read of the hardware mask
    m = xorshift();
    host.wr_rd(8'hD0, m, r);
    chk(r, m);
    // reset in mid-run restores flags and masks
    @(posedge sys_clk);
    reset_n <= 1'h0;
    @(posedge sys_clk);
    reset_n <= 1'h1;
    rchk(8'hC2, 8'h04);
    rchk(8'hD0, 8'hFF);
    rchk(8'hD1, 8'hFF);
    summarize();
  end
endmodule : test_dsle_bank
